// ===== core/emb_block.sv
// Notes on behaviour
// - RAM ratios 128x16 down to 2048x1
// - Write strobe made internally from clock
// - Up to 2048 words; width needs nothing
// - Page decoder enables shared-line driver
// - Low eleven address bits common, two page
// - With decode on only the selected page drives, with it off every page; none drives in CAM mode
// - Ten local outputs, nine distinct
// - CAM holds 32 entries of 32 bits
// - Don't-care bits never cause mismatch
// - Encoded mode gives matching entry address
// - Unencoded: 32 lines, sixteen per cycle over two cycles
// - Duplicates make encoded result invalid
// - Entry write two cycles, three with mask
// - Entries loadable at setup or runtime
module emb_block (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // RAM port from fabric
    input  wire logic        ram_we,
    input  wire logic [12:0] ram_addr,
    input  wire logic [15:0] ram_wdata,
    output logic      [15:0] ram_rdata,
    // Shared column read line
    output logic      [15:0] col_line_o,
    output logic             col_line_oe,
    // Local feedback to neighbouring logic cells
    output logic      [9:0]  local_out,
    // CAM write from fabric
    input  wire logic        cam_wr_req,
    input  wire logic [4:0]  cam_wr_idx,
    input  wire logic [31:0] cam_wr_data,
    input  wire logic [31:0] cam_wr_dc,
    output logic             cam_busy,
    // CAM search from fabric
    input  wire logic        srch_req,
    input  wire logic [31:0] srch_key,
    output logic             srch_ready,
    output logic             res_valid,
    output logic             res_phase,
    output logic      [15:0] res_data,
    output logic             match_found,
    output logic             multi_match
);

    // ---------------- Register file ----------------
    // Five word registers on the bus
    // Control keeps its low byte only
    // Unused bits read back as zero
    // Miss or status write: error, no effect
    logic [7:0]  ctrl_reg;       // Mode, geometry, output form, page
    logic [31:0] ld_data_reg;    // Setup-load data word
    logic [31:0] ld_mask_reg;    // Setup-load don't-care word
    logic [31:0] prdata_reg;     // Read data captured in setup phase
    logic        slverr_reg;     // Error captured in setup phase

    // Fields of the control word
    wire         cam_mode  = ctrl_reg[emb_pkg::CTRL_MODE_BIT];
    wire  [2:0]  geo       = ctrl_reg[emb_pkg::CTRL_GEO_LSB +: 3];
    wire         unenc     = ctrl_reg[emb_pkg::CTRL_UNENC_BIT];
    wire         page_en   = ctrl_reg[emb_pkg::CTRL_PAGE_EN];
    wire  [1:0]  page_id   = ctrl_reg[emb_pkg::CTRL_PAGE_LSB +: 2];

    // Bus phase and address decode
    wire         apb_setup = psel & ~penable;
    wire         apb_wr    = psel & penable & pwrite;
    wire         hit_ctrl  = (paddr == emb_pkg::CTRL_OFS);
    wire         hit_stat  = (paddr == emb_pkg::STATUS_OFS);
    wire         hit_dat   = (paddr == emb_pkg::CAM_DATA_OFS);
    wire         hit_msk   = (paddr == emb_pkg::CAM_MASK_OFS);
    wire         hit_ld    = (paddr == emb_pkg::CAM_LOAD_OFS);
    wire         mapped    = hit_ctrl | hit_stat | hit_dat | hit_msk |
                             hit_ld;

    // Status sources
    logic [4:0]  last_enc_reg;   // Last encoded search address
    logic [31:0] status_word;    // Assembled status view
    logic [31:0] rd_mux;         // Selected read value

    assign status_word = {24'h000000, last_enc_reg, multi_match,
                          match_found, cam_busy};

    // Read selection by address
    assign rd_mux = hit_ctrl ? {24'h000000, ctrl_reg} :
                    hit_stat ? status_word :
                    hit_dat  ? ld_data_reg :
                    hit_msk  ? ld_mask_reg :
                    32'h0000_0000;

    // Slave never stalls
    // Read word latched at setup edge
    // Status moving in access shows next time
    // Zero wait states: data captured during setup
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = slverr_reg & psel & penable;

    // Load trigger reads as zero
    // Setup-phase capture of read data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else if (apb_setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
            slverr_reg <= ~mapped | (pwrite & hit_stat);
        end
    end

    // Commit only at the access edge
    // Aborted setup leaves registers alone
    // Writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= emb_pkg::CTRL_RESET;
            ld_data_reg <= 32'h0000_0000;
            ld_mask_reg <= 32'h0000_0000;
        end else if (apb_wr) begin
            if (hit_ctrl) begin
                ctrl_reg <= pwdata[7:0];
            end else if (hit_dat) begin
                ld_data_reg <= pwdata;
            end else if (hit_msk) begin
                ld_mask_reg <= pwdata;
            end
        end
    end

    // ---------------- RAM and depth expansion ----------------
    // Eleven address bits common to a column
    // Two bits above pick the page
    // Decode off: block answers every page
    // Decode on: only the owner writes
    // Four blocks, four ids, no collision
    logic [1:0] page_sel;       // Upper two address bits
    logic       page_hit;       // This block owns the addressed page
    logic       page_hit_reg;   // Page ownership aligned with read data
    logic [15:0] ram_q;         // Registered core read data

    assign page_sel = ram_addr[emb_pkg::ADDR_W-1:emb_pkg::PAGE_LSB];
    assign page_hit = ~page_en | (page_sel == page_id);

    // Writes refused in CAM mode
    // Single-block use needs no outside control; writes gated by page
    emb_ram u_ram (
        .pclk  (pclk),
        .we    (ram_we & ~cam_mode & page_hit),
        .addr  (ram_addr[emb_pkg::PAGE_LSB-1:0]),
        .geo   (geo),
        .wdata (ram_wdata),
        .rdata (ram_q)
    );

    // Enable aligned with the registered word
    // Live decode would drive stale data
    // for one cycle after a page change
    // Page ownership registered on the same edge as the read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_hit_reg <= 1'b0;
        end else begin
            page_hit_reg <= page_hit & ~cam_mode;
        end
    end

    // Exactly one block per column owns each page, so no contention
    assign ram_rdata   = ram_q;
    assign col_line_o  = page_hit_reg ? ram_q : 16'h0000;
    assign col_line_oe = page_hit_reg;

    // Short path for neighbouring logic cells
    // Nine distinct lines, tenth repeats bit zero
    assign local_out = {ram_q[0], ram_q[8:0]};

    // ---------------- CAM write sequencer ----------------
    // Accept in idle, then data cycle
    // Data cycle clears don't-care bits
    // Mask cycle only if any bit is set
    // Fabric port wins a tie with a load
    // A losing load is dropped silently
    // Search during a write sees it half done
    emb_pkg::emb_wstate_type wst_reg;   // Sequencer state
    emb_pkg::emb_wstate_type wst_next;  // Next sequencer state
    logic [4:0]  widx_reg;              // Entry being written
    logic [31:0] wdata_reg;             // Captured data
    logic [31:0] wdc_reg;               // Captured don't-care bits
    logic        fab_take;              // Fabric write accepted
    logic        ld_take;               // Setup-load write accepted
    logic        wr_take;               // Any write accepted

    assign fab_take = cam_wr_req & (wst_reg == emb_pkg::EMB_W_IDLE);
    assign ld_take  = apb_wr & hit_ld & ~cam_wr_req &
                      (wst_reg == emb_pkg::EMB_W_IDLE);
    assign wr_take  = fab_take | ld_take;
    assign cam_busy = (wst_reg != emb_pkg::EMB_W_IDLE);

    // Mask cycle skipped when no bit is set
    // Next-state: accept, data cycle, optional mask cycle
    always_comb begin
        wst_next = wst_reg;
        case (wst_reg)
            emb_pkg::EMB_W_IDLE: begin
                if (wr_take) begin
                    wst_next = emb_pkg::EMB_W_DATA;
                end
            end
            emb_pkg::EMB_W_DATA: begin
                if (wdc_reg != 32'h0000_0000) begin
                    wst_next = emb_pkg::EMB_W_MASK;
                end else begin
                    wst_next = emb_pkg::EMB_W_IDLE;
                end
            end
            emb_pkg::EMB_W_MASK: begin
                wst_next = emb_pkg::EMB_W_IDLE;
            end
            default: begin
                wst_next = emb_pkg::EMB_W_IDLE;
            end
        endcase
    end

    // Sequencer state and captured operands are reset
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wst_reg <= emb_pkg::EMB_W_IDLE;
        end else begin
            wst_reg <= wst_next;
        end
    end

    // Operands held from acceptance on
    // Requester may move on once busy rises
    // Capture of the entry to write; fabric wins over setup load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            widx_reg  <= 5'h00;
            wdata_reg <= 32'h0000_0000;
            wdc_reg   <= 32'h0000_0000;
        end else if (fab_take) begin
            widx_reg  <= cam_wr_idx;
            wdata_reg <= cam_wr_data;
            wdc_reg   <= cam_wr_dc;
        end else if (ld_take) begin
            widx_reg  <= pwdata[4:0];
            wdata_reg <= ld_data_reg;
            wdc_reg   <= ld_mask_reg;
        end
    end

    // ---------------- CAM search ----------------
    // Taken when ready, answers next edge
    // Encoded: one cycle with the index
    // Unencoded: two cycles, low half first
    // Next search held off until upper half
    // Match flags stand until next search
    logic [31:0] hits;          // Live match vector
    logic [31:0] hi_hits_reg;   // Upper entries held for second cycle
    logic        second_reg;    // Unencoded second cycle pending
    logic        srch_take;     // Search accepted
    logic [4:0]  enc;           // Lowest matching entry
    logic        any_hit;       // At least one entry matches
    logic        many_hit;      // More than one entry matches

    emb_cam u_cam (
        .pclk    (pclk),
        .we_data (wst_reg == emb_pkg::EMB_W_DATA),
        .we_mask (wst_reg == emb_pkg::EMB_W_MASK),
        .widx    (widx_reg),
        .wword   ((wst_reg == emb_pkg::EMB_W_MASK) ? wdc_reg : wdata_reg),
        .key     (srch_key),
        .hits    (hits)
    );

    // Several hits leave the index ambiguous
    // multi_match reports that case
    // Lowest-index encoder; with duplicates this pick is not reliable
    always_comb begin
        enc = 5'h00;
        for (int i = emb_pkg::CAM_WORDS - 1; i >= 0; i--) begin
            if (hits[i]) begin
                enc = 5'(i);
            end
        end
    end

    // Flags from live hits; handshake from mode and second cycle
    assign any_hit    = |hits;
    assign many_hit   = (hits & (hits - 32'h0000_0001)) != 32'h0000_0000;
    assign srch_ready = cam_mode & ~second_reg;
    assign srch_take  = srch_req & srch_ready;

    // Second unencoded cycle has priority
    // Ready is low then, so none is lost
    // Result output: encoded one cycle, unencoded two halves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid    <= 1'b0;
            res_phase    <= 1'b0;
            res_data     <= 16'h0000;
            match_found  <= 1'b0;
            multi_match  <= 1'b0;
            second_reg   <= 1'b0;
            hi_hits_reg  <= 32'h0000_0000;
            last_enc_reg <= 5'h00;
        end else if (second_reg) begin
            res_valid  <= 1'b1;
            res_phase  <= 1'b1;
            res_data   <= hi_hits_reg[31:16];
            second_reg <= 1'b0;
        end else if (srch_take) begin
            res_valid    <= 1'b1;
            res_phase    <= 1'b0;
            match_found  <= any_hit;
            multi_match  <= many_hit;
            last_enc_reg <= enc;
            hi_hits_reg  <= hits;
            second_reg   <= unenc;
            if (unenc) begin
                res_data <= hits[15:0];
            end else begin
                res_data <= {11'h000, enc};
            end
        end else begin
            res_valid <= 1'b0;
            res_phase <= 1'b0;
        end
    end

endmodule : emb_block

// ===== core/emb_pkg.sv
package emb_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h04;
    localparam logic [7:0] CAM_DATA_OFS = 8'h08;
    localparam logic [7:0] CAM_MASK_OFS = 8'h0c;
    localparam logic [7:0] CAM_LOAD_OFS = 8'h10;

    // Control register fields
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_GEO_LSB   = 1;
    localparam int CTRL_UNENC_BIT = 4;
    localparam int CTRL_PAGE_EN   = 5;
    localparam int CTRL_PAGE_LSB  = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Memory shape
    localparam int RAM_ROWS   = 128;
    localparam int RAM_WIDTH  = 16;
    localparam int ADDR_W     = 13;
    localparam int PAGE_LSB   = 11;
    localparam int CAM_WORDS  = 32;
    localparam int CAM_WIDTH  = 32;
    localparam logic [2:0] GEO_MAX = 3'h4;

    // Content-addressable write sequencer
    typedef enum logic [1:0] {
        EMB_W_IDLE = 2'b00,
        EMB_W_DATA = 2'b01,
        EMB_W_MASK = 2'b10
    } emb_wstate_type;

    // One stored entry: data and per-bit don't-care
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] dc;
    } emb_entry_type;

    // Geometry code above the largest ratio acts as 2048 x 1
    function automatic logic [2:0] emb_geo(input logic [2:0] g);
        emb_geo = (g > GEO_MAX) ? GEO_MAX : g;
    endfunction : emb_geo

    // Bits of one word at this geometry, as a low mask
    function automatic logic [15:0] emb_wmask(input logic [2:0] g);
        emb_wmask = 16'hffff >> (5'h10 - (5'h10 >> emb_geo(g)));
    endfunction : emb_wmask

    // Bit position of the addressed word inside its row
    function automatic logic [3:0] emb_shift(input logic [10:0] a,
                                             input logic [2:0]  g);
        logic [3:0] lane;
        logic [3:0] width;
        lane  = a[3:0] & 4'((4'h1 << emb_geo(g)) - 4'h1);
        width = 4'(5'h10 >> emb_geo(g));
        emb_shift = 4'(lane * width);
    endfunction : emb_shift

    // Physical row that holds the addressed word
    function automatic logic [6:0] emb_row(input logic [10:0] a,
                                           input logic [2:0]  g);
        emb_row = 7'(a >> emb_geo(g));
    endfunction : emb_row

endpackage : emb_pkg

// ===== core/emb_ram.sv
// Synchronous RAM core, 128 rows of 16 bits, five aspect ratios
module emb_ram (
    input  wire logic        pclk,
    input  wire logic        we,
    input  wire logic [10:0] addr,
    input  wire logic [2:0]  geo,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata
);
    logic [15:0] mem [0:emb_pkg::RAM_ROWS-1];  // Storage rows
    logic [6:0]  row;                           // Selected row
    logic [3:0]  shift;                         // Word position in row
    logic [15:0] lane_mask;                     // Bits of the word in row

    assign row       = emb_pkg::emb_row(addr, geo);
    assign shift     = emb_pkg::emb_shift(addr, geo);
    assign lane_mask = emb_pkg::emb_wmask(geo) << shift;

    // Write strobe is the clock edge itself; no separate pulse exists
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[row] <= (mem[row] & ~lane_mask) |
                        ((wdata << shift) & lane_mask);
        end
    end

    // Registered read, word right-aligned and zero-padded above
    always_ff @(posedge pclk) begin
        rdata <= (mem[row] >> shift) & emb_pkg::emb_wmask(geo);
    end
endmodule : emb_ram

// ===== core/emb_cam.sv
// Content-addressable store: 32 entries with don't-care bits
module emb_cam (
    input  wire logic        pclk,
    input  wire logic        we_data,
    input  wire logic        we_mask,
    input  wire logic [4:0]  widx,
    input  wire logic [31:0] wword,
    input  wire logic [31:0] key,
    output logic      [31:0] hits
);
    emb_pkg::emb_entry_type ent [0:emb_pkg::CAM_WORDS-1];  // Entries

    // Data phase clears don't-cares, mask phase sets them
    always_ff @(posedge pclk) begin
        if (we_data) begin
            ent[widx].data <= wword;
            ent[widx].dc   <= 32'h0000_0000;
        end else if (we_mask) begin
            ent[widx].dc <= wword;
        end
    end

    // Compare the key against every entry at once
    always_comb begin
        for (int i = 0; i < emb_pkg::CAM_WORDS; i++) begin
            hits[i] = (((ent[i].data ^ key) & ~ent[i].dc) == 32'h0);
        end
    end
endmodule : emb_cam

// ===== verif/emb_block_asserts.sv
// Port-level checks on the memory block
module emb_block_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pslverr,
    input wire logic [15:0] ram_rdata,
    input wire logic [15:0] col_line_o,
    input wire logic        col_line_oe,
    input wire logic [9:0]  local_out,
    input wire logic        cam_wr_req,
    input wire logic [31:0] cam_wr_dc,
    input wire logic        cam_busy,
    input wire logic        srch_req,
    input wire logic        srch_ready,
    input wire logic        res_valid,
    input wire logic        res_phase,
    input wire logic        match_found,
    input wire logic        multi_match
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Busy shapes of an entry write
    sequence busy_one;
        cam_busy ##1 !cam_busy;
    endsequence
    sequence busy_two;
        cam_busy [*2] ##1 !cam_busy;
    endsequence
    chk_busy_short: assert property (
        cam_wr_req && !cam_busy && cam_wr_dc == 32'h0 |=> busy_one)
        else $error("plain entry write busy length wrong");
    chk_busy_long: assert property (
        cam_wr_req && !cam_busy && cam_wr_dc != 32'h0 |=> busy_two)
        else $error("masked entry write busy length wrong");
    chk_oe_float: assert property (
        !col_line_oe |-> col_line_o == 16'h0)
        else $error("column line driven while not owner");
    chk_oe_data: assert property (
        col_line_oe |-> col_line_o === ram_rdata)
        else $error("column line data differs from read word");
    chk_local_map: assert property (
        local_out === {ram_rdata[0], ram_rdata[8:0]})
        else $error("local feedback lines wrong");
    chk_srch_answer: assert property (
        srch_req && srch_ready |=> res_valid && !res_phase)
        else $error("search result not one cycle later");
    chk_phase_pair: assert property (
        res_valid && res_phase |-> $past(res_valid && !res_phase)
            && $past(srch_req && srch_ready, 2))
        else $error("second result cycle out of order");
    chk_multi_found: assert property (
        multi_match |-> match_found)
        else $error("multiple match without match flag");
    chk_err_phase: assert property (
        pslverr |-> psel && penable)
        else $error("bus error outside access phase");
endmodule : emb_block_asserts

bind emb_block emb_block_asserts u_chk (.pclk, .presetn, .psel, .penable,
    .pslverr, .ram_rdata, .col_line_o, .col_line_oe, .local_out,
    .cam_wr_req, .cam_wr_dc, .cam_busy, .srch_req, .srch_ready,
    .res_valid, .res_phase, .match_found, .multi_match);

// ===== verif/emb_fabric_model.sv
// Fabric user logic driving RAM and CAM ports
module emb_fabric_model (
    input  wire logic        pclk,
    input  wire logic [15:0] ram_rdata,
    input  wire logic        col_line_oe,
    input  wire logic        cam_busy,
    input  wire logic        srch_ready,
    input  wire logic        res_valid,
    input  wire logic        res_phase,
    input  wire logic [15:0] res_data,
    output logic             ram_we,
    output logic      [12:0] ram_addr,
    output logic      [15:0] ram_wdata,
    output logic             cam_wr_req,
    output logic      [4:0]  cam_wr_idx,
    output logic      [31:0] cam_wr_data,
    output logic      [31:0] cam_wr_dc,
    output logic             srch_req,
    output logic      [31:0] srch_key
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {ram_we, ram_addr, ram_wdata} = '0;
        {cam_wr_req, cam_wr_idx, cam_wr_data, cam_wr_dc} = '0;
        {srch_req, srch_key} = '0;
    end
    // One RAM cycle, word sampled once it has settled
    task automatic ram_op(input logic we, input logic [12:0] a,
            input logic [15:0] d, output logic [15:0] q,
            output logic oe);
        @(posedge pclk);
        ram_we    <= we;
        ram_addr  <= a;
        ram_wdata <= d;
        @(posedge pclk);
        ram_we    <= 1'b0;
        ram_wdata <= ~d;
        @(posedge pclk);
        #1;
        q  = ram_rdata;
        oe = col_line_oe;
    endtask : ram_op
    // Entry write held until taken, then wait for idle
    task automatic cam_wr(input logic [4:0] i, input logic [31:0] d, m);
        @(posedge pclk);
        cam_wr_req  <= 1'b1;
        cam_wr_idx  <= i;
        cam_wr_data <= d;
        cam_wr_dc   <= m;
        do @(posedge pclk); while (cam_busy);
        cam_wr_req  <= 1'b0;
        cam_wr_data <= ~d;
        do @(posedge pclk); while (cam_busy);
    endtask : cam_wr
    // Search; both result cycles are captured
    task automatic search(input logic [31:0] k,
            output logic [15:0] r0, r1, output logic v0, v1);
        @(posedge pclk);
        srch_req <= 1'b1;
        srch_key <= k;
        do @(posedge pclk); while (!srch_ready);
        srch_req <= 1'b0;
        srch_key <= ~k;
        #1;
        v0 = res_valid && !res_phase;
        r0 = res_data;
        @(posedge pclk);
        #1;
        v1 = res_valid && res_phase;
        r1 = res_data;
    endtask : search
endmodule : emb_fabric_model

// ===== verif/emb_block_tb.sv
// Self-checking bench for the memory block
module emb_block_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, cam_wr_data, cam_wr_dc, srch_key;
    logic ram_we, col_line_oe, cam_wr_req, cam_busy, srch_req;
    logic srch_ready, res_valid, res_phase, match_found, multi_match;
    logic [12:0] ram_addr, a;
    logic [15:0] ram_wdata, ram_rdata, col_line_o, res_data;
    logic [15:0] q, r0, r1, d0, d1, m;
    logic [9:0] local_out;
    logic [4:0] cam_wr_idx;
    logic [31:0] rd, b, e [32];
    logic err, oe, v0, v1;
    int failures, cmp_count, cyc;
    wire logic [15:0] col_wire; // Pulled-up shared line
    assign col_wire = col_line_oe ? col_line_o : 16'hffff;
    emb_block u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ram_we, .ram_addr,
        .ram_wdata, .ram_rdata, .col_line_o, .col_line_oe, .local_out,
        .cam_wr_req, .cam_wr_idx, .cam_wr_data, .cam_wr_dc, .cam_busy,
        .srch_req, .srch_key, .srch_ready, .res_valid, .res_phase,
        .res_data, .match_found, .multi_match);
    emb_fabric_model u_fab (.pclk, .ram_rdata, .col_line_oe, .cam_busy,
        .srch_ready, .res_valid, .res_phase, .res_data, .ram_we,
        .ram_addr, .ram_wdata, .cam_wr_req, .cam_wr_idx, .cam_wr_data,
        .cam_wr_dc, .srch_req, .srch_key);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            failures++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] ad,
            input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Used bits of one word at a geometry code
    function automatic logic [15:0] wmask(input int g);
        return 16'hffff >> (16 - (16 >> (g > 4 ? 4 : g)));
    endfunction : wmask
    // Search and compare result cycles and flags
    task automatic find(input logic [31:0] k, input logic u,
            input logic [15:0] x0, x1, input logic [1:0] mm);
        u_fab.search(k, r0, r1, v0, v1);
        chk({v0, v1}, {1'b1, u});
        chk(r0, x0);
        if (u)
            chk(r1, x1);
        chk({multi_match, match_found}, mm);
    endtask : find
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(35152));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h20, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        // Every geometry code, one above the range too
        for (int g = 0; g < 6; g++) begin
            apb(1'b1, 8'h00, g << 1);
            a  = 13'($urandom) & 13'h1ffe;
            d0 = 16'($urandom);
            d1 = 16'($urandom);
            m  = d0 & wmask(g);
            u_fab.ram_op(1'b1, a, d0, q, oe);
            u_fab.ram_op(1'b1, a | 13'h1, d1, q, oe);
            u_fab.ram_op(1'b0, a, 16'h0, q, oe);
            chk(q, m);
            chk(col_wire, m);
            chk(local_out, {m[0], m[8:0]});
            u_fab.ram_op(1'b0, a | 13'h1, 16'h0, q, oe);
            chk(q, d1 & wmask(g));
        end
        // Page decode: this block owns page 2 only
        apb(1'b1, 8'h00, 32'ha0);
        a = {2'h2, 11'($urandom)};
        u_fab.ram_op(1'b1, a, d0, q, oe);
        u_fab.ram_op(1'b1, a ^ 13'h0800, ~d0, q, oe);
        chk({oe, col_wire}, {1'b0, 16'hffff});
        u_fab.ram_op(1'b0, a, 16'h0, q, oe);
        chk({oe, q}, {1'b1, d0});
        // Fill: even entries over APB, odd from fabric
        apb(1'b1, 8'h00, 32'h1);
        b = $urandom & 32'hffffffe0;
        for (int i = 0; i < 32; i++) begin
            e[i] = b | 32'(i);
            if (i[0])
                u_fab.cam_wr(5'(i), e[i], i == 21 ? 32'hff00 : 32'h0);
            else begin
                apb(1'b1, 8'h08, e[i]);
                apb(1'b1, 8'h0c, i == 20 ? 32'hff00 : 32'h0);
                apb(1'b1, 8'h10, i);
            end
        end
        find(e[12], 1'b0, 16'd12, 16'h0, 2'b01);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h62);
        find(e[21] ^ 32'h5a00, 1'b0, 16'd21, 16'h0, 2'b01);
        u_fab.cam_wr(5'd5, e[12], 32'h0);
        find(e[12], 1'b0, 16'd5, 16'h0, 2'b11);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h2e);
        apb(1'b1, 8'h00, 32'h11);
        find(e[12], 1'b1, 16'h1020, 16'h0, 2'b11);
        find(e[21] ^ 32'h5a00, 1'b1, 16'h0, 16'h20, 2'b01);
        find(~b, 1'b1, 16'h0, 16'h0, 2'b00);
        apb(1'b1, 8'h00, 32'h0);
        @(posedge pclk);
        #1;
        chk(srch_ready, 1'b0);
        finish_test();
    end
endmodule : emb_block_tb
